//--- protected_register_write_guard.sv
// Protected register write guard with peripheral access timing.
// Assumes one CPU peripheral access at a time on the system clock.
`timescale 1ns/100ps
`include "guard_map.svh"
module protected_register_write_guard (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_acc_req,
  input wire logic i_acc_write,
  input wire logic i_acc_wide,
  input wire logic i_acc_bit,
  input wire logic [31:0] i_acc_addr,
  input wire logic [7:0] i_acc_wdata,
  input wire logic [2:0] i_acc_bitpos,
  input wire logic i_status_clash,
  output logic o_acc_busy,
  output logic o_acc_done,
  output logic [7:0] o_acc_rdata,
  output logic [7:0] o_power_save_control,
  output logic [7:0] o_processor_clock_control,
  output logic [7:0] o_clock_control_setting,
  output logic [7:0] o_watchdog_mode_setting,
  output logic [7:0] o_watchdog_reset_status,
  output logic [7:0] o_peripheral_wait_control,
  output logic o_protection_error_flag
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    guard_pkg::bus_state_e state;
    logic write;
    logic wide;
    logic bitop;
    logic [31:0] addr;
    logic [7:0] wdata;
    logic [2:0] bitpos;
    logic busy;
    logic done;
    logic [7:0] rdata;
    logic [7:0] wait_ctrl;
    logic [`PROT_COUNT-1:0][7:0] prot;
    logic [6:0] hlp_cnt;
    logic hlp_retry;
    logic [6:0] hlp_total;
  } core_s;

  // Entry order: power save, cpu clock, clock ctrl, watchdog mode, watchdog reset
  localparam logic [`PROT_COUNT-1:0][31:0] PROT_ADDR = {
    `ADDR_WDOG_RESET, `ADDR_WDOG_MODE, `ADDR_CLOCK_CTRL, `ADDR_CPU_CLOCK, `ADDR_POWER_SAVE
  };

  core_s cur_r, cur_nxt;
  guard_if gif ();
  logic [`PROT_COUNT-1:0] prot_hit;
  logic [4:0] wait_sum;
  logic take;
  logic finish;
  logic grant;
  logic [2:0] prot_idx;
  logic [7:0] status_view;

  // ****************************************
  // Helpers
  // ****************************************
  access_timer u_timer (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .gif(gif.timer)
  );

  unlock_tracker u_tracker (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .gif(gif.tracker)
  );

  // Merge a single-bit store into a byte
  function automatic logic [7:0] bit_merge(input logic [7:0] old, input logic [2:0] pos,
                                           input logic val);
    logic [7:0] res;
    res = old;
    res[pos] = val;
    return res;
  endfunction : bit_merge

  // ****************************************
  // Decode
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `PROT_COUNT; g++) begin : g_prot
      assign prot_hit[g] = (cur_r.addr == PROT_ADDR[g]);
    end
  endgenerate

  always_comb begin
    prot_idx = 3'h0;
    for (int k = 0; k < `PROT_COUNT; k++) begin
      if (prot_hit[k]) prot_idx = 3'(k);
    end
  end

  // Waits are the sum of both nibbles of the wait setting
  assign wait_sum = {1'b0, cur_r.wait_ctrl[`WAIT_FIELD_LO]}
                  + {1'b0, cur_r.wait_ctrl[`WAIT_FIELD_HI]};
  assign take = (cur_r.state == guard_pkg::ST_IDLE) && i_acc_req;
  assign finish = (cur_r.state == guard_pkg::ST_WAIT) && gif.tm_expire;

  assign gif.tm_start = take;
  assign gif.tm_reload = `BASE_ACCESS_CLKS - `ACCESS_PIPE_CLKS + {1'b0, wait_sum};
  assign gif.tm_clash = (cur_r.state == guard_pkg::ST_WAIT) && i_status_clash;
  assign gif.ev_valid = finish;

  always_comb begin
    if (!cur_r.write) begin
      gif.ev_kind = guard_pkg::EV_READ;
    end else if (cur_r.addr == `ADDR_UNLOCK_CMD && !cur_r.wide && !cur_r.bitop) begin
      gif.ev_kind = guard_pkg::EV_CMD;
    end else if (cur_r.addr == `ADDR_WDOG_MODE) begin
      gif.ev_kind = guard_pkg::EV_WDOG_MODE;
    end else if (|prot_hit) begin
      gif.ev_kind = guard_pkg::EV_PROT;
    end else if (cur_r.addr == `ADDR_SYSTEM_STATUS) begin
      gif.ev_kind = guard_pkg::EV_STATUS;
    end else begin
      gif.ev_kind = guard_pkg::EV_OTHER;
    end
  end

  // Byte store always reaches the flag; a bit store only at its position
  assign gif.ev_status_hit = !cur_r.bitop || (cur_r.bitpos == `ERR_BIT_POS);
  assign gif.ev_err_val = cur_r.bitop ? cur_r.wdata[0] : cur_r.wdata[`ERR_BIT_POS];

  // Reads in between only void the unlock for the watchdog mode register
  assign grant = gif.unlocked
               && ((gif.ev_kind == guard_pkg::EV_PROT)
                   || (gif.ev_kind == guard_pkg::EV_WDOG_MODE && !gif.rd_seen));

  always_comb begin
    status_view = `RST_SYSTEM_STATUS;
    status_view[`ERR_BIT_POS] = gif.err_flag;
  end

  // ****************************************
  // Access sequencing and register effects
  // ****************************************
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.done = 1'b0;
    case (cur_r.state)
      guard_pkg::ST_IDLE: begin
        if (take) begin
          cur_nxt.state = guard_pkg::ST_WAIT;
          cur_nxt.busy = 1'b1;
          cur_nxt.write = i_acc_write;
          cur_nxt.wide = i_acc_wide;
          cur_nxt.bitop = i_acc_bit;
          cur_nxt.addr = i_acc_addr;
          cur_nxt.wdata = i_acc_wdata;
          cur_nxt.bitpos = i_acc_bitpos;
          cur_nxt.hlp_cnt = 7'h01;
          cur_nxt.hlp_retry = 1'b0;
          cur_nxt.hlp_total = 7'({1'b0, `BASE_ACCESS_CLKS} + {2'b00, wait_sum});
        end
      end
      guard_pkg::ST_WAIT: begin
        cur_nxt.hlp_cnt = cur_r.hlp_cnt + 7'h01;
        if (gif.tm_retry) cur_nxt.hlp_retry = 1'b1;
        if (finish) begin
          cur_nxt.state = guard_pkg::ST_IDLE;
          cur_nxt.busy = 1'b0;
          cur_nxt.done = 1'b1;
          cur_nxt.rdata = `UNDEF_READ;
          if (!cur_r.write) begin
            if (cur_r.addr == `ADDR_WAIT_CTRL) begin
              cur_nxt.rdata = cur_r.wait_ctrl;
            end else if (cur_r.addr == `ADDR_SYSTEM_STATUS) begin
              cur_nxt.rdata = status_view;
            end else if (|prot_hit) begin
              cur_nxt.rdata = cur_r.prot[prot_idx];
            end
          end else if (grant) begin
            // Protected registers are written only with the unlock held
            cur_nxt.prot[prot_idx] = cur_r.bitop
              ? bit_merge(cur_r.prot[prot_idx], cur_r.bitpos, cur_r.wdata[0])
              : cur_r.wdata;
          end else if (cur_r.addr == `ADDR_WAIT_CTRL && !cur_r.bitop && !cur_r.wide) begin
            cur_nxt.wait_ctrl = cur_r.wdata;
          end
        end
      end
      default: begin
        cur_nxt.state = guard_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cur_r <= '0;
      cur_r.state <= guard_pkg::ST_IDLE;
      cur_r.wait_ctrl <= `RST_WAIT_CTRL;
      cur_r.prot <= {`PROT_COUNT{`RST_PROT_REG}};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_acc_busy = cur_r.busy;
  assign o_acc_done = cur_r.done;
  assign o_acc_rdata = cur_r.rdata;
  assign o_power_save_control = cur_r.prot[0];
  assign o_processor_clock_control = cur_r.prot[1];
  assign o_clock_control_setting = cur_r.prot[2];
  assign o_watchdog_mode_setting = cur_r.prot[3];
  assign o_watchdog_reset_status = cur_r.prot[4];
  assign o_peripheral_wait_control = cur_r.wait_ctrl;
  assign o_protection_error_flag = gif.err_flag;

  // ****************************************
  // Checks
  // ****************************************
  chk_cmd_unlocks: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && gif.ev_kind == guard_pkg::EV_CMD |=> gif.unlocked)
    else $error("unlock write did not unlock");

  chk_locked_write_kept: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && cur_r.write && (|prot_hit) && !gif.unlocked
    |=> cur_r.prot == $past(cur_r.prot))
    else $error("protected register changed without unlock");

  chk_err_no_unlock: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && gif.ev_kind == guard_pkg::EV_PROT && !gif.unlocked |=> gif.err_flag)
    else $error("locked protected write left error clear");

  chk_err_other_write: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && gif.ev_kind == guard_pkg::EV_OTHER && gif.unlocked
    |=> gif.err_flag && !gif.unlocked)
    else $error("write to other register after unlock not flagged");

  chk_err_write_value: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && gif.ev_kind == guard_pkg::EV_STATUS && gif.ev_status_hit
    |=> gif.err_flag == $past(gif.ev_err_val))
    else $error("error flag does not follow written value");

  chk_zero_wins: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && gif.ev_kind == guard_pkg::EV_STATUS && gif.ev_status_hit
    && !gif.ev_err_val && gif.unlocked |=> !gif.err_flag)
    else $error("zero write after unlock did not clear error");

  chk_read_keeps_unlock: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && !cur_r.write && gif.unlocked |=> gif.unlocked && gif.rd_seen)
    else $error("read cancelled the unlock");

  chk_unlock_ends: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && cur_r.write && gif.ev_kind != guard_pkg::EV_CMD |=> !gif.unlocked)
    else $error("unlock survived a write");

  chk_reset_values: assert property (@(posedge i_sys_clk)
    i_srst |=> !gif.err_flag && cur_r.wait_ctrl == `RST_WAIT_CTRL)
    else $error("reset values wrong");

  chk_access_length: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    cur_r.done && !cur_r.hlp_retry |-> cur_r.hlp_cnt == cur_r.hlp_total)
    else $error("access length differs from base plus waits");

  chk_busy_until_done: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    take |=> cur_r.busy [*2] ##1 (cur_r.busy || cur_r.done))
    else $error("access shorter than three clocks");

  chk_cmd_read_undef: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && !cur_r.write && cur_r.addr == `ADDR_UNLOCK_CMD |=> cur_r.rdata == `UNDEF_READ)
    else $error("unlock command read returned data");

  chk_granted_write_lands: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && grant && !cur_r.bitop
    |=> cur_r.prot[$past(prot_idx)] == $past(cur_r.wdata))
    else $error("unlocked protected write lost");

  chk_other_keeps_prot: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && !(|prot_hit) |=> cur_r.prot == $past(cur_r.prot))
    else $error("unprotected address changed a protected register");

  chk_bit_status_other: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && gif.ev_kind == guard_pkg::EV_STATUS && !gif.ev_status_hit && gif.unlocked
    |=> gif.err_flag)
    else $error("bit store beside the flag after unlock not flagged");

  chk_wdog_read_voids: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && gif.ev_kind == guard_pkg::EV_WDOG_MODE && gif.rd_seen
    |=> gif.err_flag
        && cur_r.prot[`PROT_IDX_WDOG_MODE] == $past(cur_r.prot[`PROT_IDX_WDOG_MODE]))
    else $error("watchdog mode written after a read in between");

  chk_err_held: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !finish |=> $stable(gif.err_flag))
    else $error("error flag moved without an access");

  chk_status_read_flag: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && !cur_r.write && cur_r.addr == `ADDR_SYSTEM_STATUS
    |=> cur_r.rdata[`ERR_BIT_POS] == $past(gif.err_flag))
    else $error("status read does not show the error flag");

  chk_wait_byte_write: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && cur_r.write && cur_r.addr == `ADDR_WAIT_CTRL && !cur_r.wide && !cur_r.bitop
    |=> cur_r.wait_ctrl == $past(cur_r.wdata))
    else $error("byte write to wait control lost");

  chk_wait_odd_ignored: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    finish && cur_r.write && cur_r.addr == `ADDR_WAIT_CTRL && (cur_r.wide || cur_r.bitop)
    |=> cur_r.wait_ctrl == $past(cur_r.wait_ctrl))
    else $error("bit or wide write changed wait control");

  chk_done_one_cycle: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    cur_r.done |-> !cur_r.busy ##1 !cur_r.done)
    else $error("done pulse too long or busy with done");

endmodule : protected_register_write_guard

//--- guard_map.svh
// Address map, reset values, field positions and timing counts of the write guard.
// Assumes a 32-bit peripheral address and 8-bit register data.
`ifndef GUARD_MAP_SVH
`define GUARD_MAP_SVH

// ****************************************
// Register addresses
// ****************************************
`define ADDR_WAIT_CTRL 32'hFFFFF06E
`define ADDR_UNLOCK_CMD 32'hFFFFF1FC
`define ADDR_SYSTEM_STATUS 32'hFFFFF802
`define ADDR_POWER_SAVE 32'hFFFFF1FE
`define ADDR_CPU_CLOCK 32'hFFFFF828
`define ADDR_CLOCK_CTRL 32'hFFFFF822
`define ADDR_WDOG_MODE 32'hFFFFF6D0
`define ADDR_WDOG_RESET 32'hFFFFF6D2

// ****************************************
// Reset values and fields
// ****************************************
`define RST_WAIT_CTRL 8'h77
`define RST_SYSTEM_STATUS 8'h00
`define RST_PROT_REG 8'h00
`define UNDEF_READ 8'h00
`define ERR_BIT_POS 3'h0
`define WAIT_FIELD_LO 3:0
`define WAIT_FIELD_HI 7:4
`define PROT_COUNT 5
`define PROT_IDX_WDOG_MODE 3'h3

// ****************************************
// Access timing
// ****************************************
`define BASE_ACCESS_CLKS 6'h03
// Take cycle plus expire cycle sit outside the countdown
`define ACCESS_PIPE_CLKS 6'h02

`endif

//--- guard_pkg.sv
// Types shared by the write guard and its helpers.
// Assumes guard_map.svh supplies the numbers.
package guard_pkg;

  typedef enum logic {ST_IDLE, ST_WAIT} bus_state_e;

  typedef enum logic [2:0] {EV_READ, EV_CMD, EV_PROT, EV_WDOG_MODE, EV_STATUS, EV_OTHER}
    ev_kind_e;

  typedef struct packed {
    logic busy;
    logic [5:0] cnt;
    logic [5:0] reload;
  } tmr_s;

  typedef struct packed {
    logic unlocked;
    logic rd_seen;
    logic err;
  } trk_s;

endpackage : guard_pkg

//--- guard_if.sv
// Carrier between the guard core, its access timer and its unlock tracker.
// Assumes all three sit on the one system clock.
`timescale 1ns/100ps
interface guard_if;
  logic ev_valid;
  guard_pkg::ev_kind_e ev_kind;
  logic ev_status_hit;
  logic ev_err_val;
  logic unlocked;
  logic rd_seen;
  logic err_flag;
  logic tm_start;
  logic [5:0] tm_reload;
  logic tm_clash;
  logic tm_expire;
  logic tm_retry;

  modport core (output ev_valid, ev_kind, ev_status_hit, ev_err_val, tm_start, tm_reload,
    tm_clash, input unlocked, rd_seen, err_flag, tm_expire, tm_retry);
  modport tracker (input ev_valid, ev_kind, ev_status_hit, ev_err_val,
    output unlocked, rd_seen, err_flag);
  modport timer (input tm_start, tm_reload, tm_clash, output tm_expire, tm_retry);
endinterface : guard_if

//--- access_timer.sv
// Counts the wait states of one peripheral register access, with retry.
// Assumes start arrives only while idle and the clash flag is on-chip logic.
`timescale 1ns/100ps
`include "guard_map.svh"
module access_timer (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  guard_if.timer gif
);
  guard_pkg::tmr_s cur_r, cur_nxt;

  assign gif.tm_expire = cur_r.busy && (cur_r.cnt == 6'h00) && !gif.tm_clash;
  assign gif.tm_retry = cur_r.busy && (cur_r.cnt == 6'h00) && gif.tm_clash;

  always_comb begin
    cur_nxt = cur_r;
    if (!cur_r.busy) begin
      if (gif.tm_start) begin
        cur_nxt.busy = 1'b1;
        cur_nxt.cnt = gif.tm_reload;
        cur_nxt.reload = gif.tm_reload;
      end
    end else if (cur_r.cnt != 6'h00) begin
      cur_nxt.cnt = cur_r.cnt - 6'h01;
    end else if (gif.tm_clash) begin
      // Value moved under the access: run the whole wait again
      cur_nxt.cnt = cur_r.reload;
    end else begin
      cur_nxt.busy = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  chk_retry_reloads: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    gif.tm_retry |=> cur_r.busy && cur_r.cnt == $past(cur_r.reload))
    else $error("retry did not restart the wait");

endmodule : access_timer

//--- unlock_tracker.sv
// Holds the unlock state and the protection error flag.
// Assumes one event pulse per completed peripheral access.
`timescale 1ns/100ps
`include "guard_map.svh"
module unlock_tracker (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  guard_if.tracker gif
);
  guard_pkg::trk_s cur_r, cur_nxt;

  assign gif.unlocked = cur_r.unlocked;
  assign gif.rd_seen = cur_r.rd_seen;
  assign gif.err_flag = cur_r.err;

  always_comb begin
    cur_nxt = cur_r;
    if (gif.ev_valid) begin
      case (gif.ev_kind)
        guard_pkg::EV_READ: begin
          if (cur_r.unlocked) cur_nxt.rd_seen = 1'b1;
        end
        guard_pkg::EV_CMD: begin
          if (cur_r.unlocked) cur_nxt.err = 1'b1;
          cur_nxt.unlocked = 1'b1;
          cur_nxt.rd_seen = 1'b0;
        end
        guard_pkg::EV_PROT: begin
          if (!cur_r.unlocked) cur_nxt.err = 1'b1;
          cur_nxt.unlocked = 1'b0;
        end
        guard_pkg::EV_WDOG_MODE: begin
          // A read in between voids the unlock for this one register
          if (!cur_r.unlocked || cur_r.rd_seen) cur_nxt.err = 1'b1;
          cur_nxt.unlocked = 1'b0;
        end
        guard_pkg::EV_STATUS: begin
          if (gif.ev_status_hit) begin
            cur_nxt.err = gif.ev_err_val;
          end else if (cur_r.unlocked) begin
            cur_nxt.err = 1'b1;
          end
          cur_nxt.unlocked = 1'b0;
        end
        default: begin
          if (cur_r.unlocked) cur_nxt.err = 1'b1;
          cur_nxt.unlocked = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  chk_err_double_cmd: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    gif.ev_valid && gif.ev_kind == guard_pkg::EV_CMD && cur_r.unlocked |=> cur_r.err)
    else $error("second unlock write did not raise the error");

endmodule : unlock_tracker

//--- cpu_bus_model.sv
// CPU-side partner: issues one peripheral register access at a time.
// Assumes the guard answers each access with a one-cycle done pulse.
`timescale 1ns/100ps
module cpu_bus_model (
  input wire logic i_sys_clk,
  input wire logic i_acc_busy,
  input wire logic i_acc_done,
  input wire logic [7:0] i_acc_rdata,
  output logic o_acc_req,
  output logic o_acc_write,
  output logic o_acc_wide,
  output logic o_acc_bit,
  output logic [31:0] o_acc_addr,
  output logic [7:0] o_acc_wdata,
  output logic [2:0] o_acc_bitpos,
  output logic o_status_clash
);
  // ****************************************
  // Idle bus
  // ****************************************
  initial begin
    o_acc_req = 1'b0;
    o_acc_write = 1'b0;
    o_acc_wide = 1'b0;
    o_acc_bit = 1'b0;
    o_acc_addr = 32'h00000000;
    o_acc_wdata = 8'h00;
    o_acc_bitpos = 3'h0;
    o_status_clash = 1'b0;
  end

  // ****************************************
  // One access, entered at a falling edge
  // ****************************************
  // Clash stays high up to count clash_to, so it spans the last wait cycle once
  task automatic access(input logic wr, input logic wide, input logic bt,
      input logic [31:0] addr, input logic [7:0] wd, input logic [2:0] bp,
      input int clash_to, output logic [7:0] rd, output int lat);
    // A fresh edge first: the last call released the lines in this time step
    @(negedge i_sys_clk);
    while (i_acc_busy !== 1'b0) @(negedge i_sys_clk);
    o_acc_req = 1'b1;
    o_acc_write = wr;
    o_acc_wide = wide;
    o_acc_bit = bt;
    o_acc_addr = addr;
    o_acc_wdata = wd;
    o_acc_bitpos = bp;
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    o_acc_req = 1'b0;
    lat = 1;
    o_status_clash = (clash_to > 1);
    // A hang is left to the bench watchdog, which counts it as a mismatch
    while (i_acc_done !== 1'b1) begin
      @(negedge i_sys_clk);
      lat++;
      if (i_acc_done !== 1'b1) o_status_clash = (lat < clash_to);
    end
    rd = i_acc_rdata;
    o_status_clash = 1'b0;
    // Released address, data and bit position lines show the inverse so a stale value never passes
    o_acc_addr = ~addr;
    o_acc_wdata = ~wd;
    o_acc_bitpos = ~bp;
    // Next store follows straight on, nothing in between
  endtask : access
endmodule : cpu_bus_model

//--- testbench.sv
// Self-checking bench for the protected register write guard.
// Assumes guard_map.svh addresses and a CPU partner model on the access port.
`timescale 1ns/100ps
`include "guard_map.svh"
`define CHECK(g, e) begin num_checks++; if ((g) !== (e)) bad(g, e); end
module testbench;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic acc_req, acc_write, acc_wide, acc_bit, status_clash, acc_busy, acc_done, err;
  logic [31:0] acc_addr;
  logic [7:0] acc_wdata, acc_rdata, wait_ctl, rd;
  logic [2:0] acc_bitpos;
  logic [7:0] prot_val [5];
  int lat;
  int n_errors = 0;
  int num_checks = 0;
  localparam logic [31:0] PROT_ADDR [5] = '{`ADDR_POWER_SAVE, `ADDR_CPU_CLOCK,
    `ADDR_CLOCK_CTRL, `ADDR_WDOG_MODE, `ADDR_WDOG_RESET};
  localparam logic [7:0] SET_VAL [3] = '{8'h12, 8'h24, 8'h11};
  localparam int SET_WAITS [3] = '{3, 6, 2};

  always #2.5 sys_clk = ~sys_clk;

  protected_register_write_guard i_protected_register_write_guard (
    .i_sys_clk(sys_clk), .i_srst(srst), .i_acc_req(acc_req), .i_acc_write(acc_write),
    .i_acc_wide(acc_wide), .i_acc_bit(acc_bit), .i_acc_addr(acc_addr),
    .i_acc_wdata(acc_wdata), .i_acc_bitpos(acc_bitpos), .i_status_clash(status_clash),
    .o_acc_busy(acc_busy), .o_acc_done(acc_done), .o_acc_rdata(acc_rdata),
    .o_power_save_control(prot_val[0]), .o_processor_clock_control(prot_val[1]),
    .o_clock_control_setting(prot_val[2]), .o_watchdog_mode_setting(prot_val[3]),
    .o_watchdog_reset_status(prot_val[4]), .o_peripheral_wait_control(wait_ctl),
    .o_protection_error_flag(err));

  cpu_bus_model i_cpu_bus_model (
    .i_sys_clk(sys_clk), .i_acc_busy(acc_busy), .i_acc_done(acc_done),
    .i_acc_rdata(acc_rdata), .o_acc_req(acc_req), .o_acc_write(acc_write),
    .o_acc_wide(acc_wide), .o_acc_bit(acc_bit), .o_acc_addr(acc_addr),
    .o_acc_wdata(acc_wdata), .o_acc_bitpos(acc_bitpos), .o_status_clash(status_clash));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic bad(input logic [31:0] g, input logic [31:0] e);
    n_errors++;
    $display("BAD t=%0t got=%h exp=%h", $time, g, e);
  endtask : bad

  task automatic wr8(input logic [31:0] a, input logic [7:0] d);
    i_cpu_bus_model.access(1'b1, 1'b0, 1'b0, a, d, 3'h0, 0, rd, lat);
  endtask : wr8

  task automatic rd8(input logic [31:0] a);
    i_cpu_bus_model.access(1'b0, 1'b0, 1'b0, a, 8'h00, 3'h0, 0, rd, lat);
  endtask : rd8

  task automatic wbit(input logic [31:0] a, input logic [2:0] p, input logic v);
    i_cpu_bus_model.access(1'b1, 1'b0, 1'b1, a, {7'h00, v}, p, 0, rd, lat);
  endtask : wbit

  // Unlock with the same data the following store carries
  task automatic unlock(input logic [7:0] d);
    wr8(`ADDR_UNLOCK_CMD, d);
  endtask : unlock

  task automatic do_reset;
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (3) @(negedge sys_clk);
    srst = 1'b0;
  endtask : do_reset

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    end_sim();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    do_reset();
    `CHECK(wait_ctl, 8'h77)
    `CHECK(err, 1'b0)
    for (int i = 0; i < 5; i++) `CHECK(prot_val[i], 8'h00)
    rd8(`ADDR_WAIT_CTRL);
    `CHECK(rd, 8'h77)
    `CHECK(lat, 17)
    `CHECK(acc_busy, 1'b0)
    $display("test reset_values done");
    // Wait setting goes first, before any other register
    // External bus is never set up here, so its order cannot be broken
    for (int i = 0; i < 3; i++) begin
      wr8(`ADDR_WAIT_CTRL, SET_VAL[i]);
      rd8(`ADDR_WAIT_CTRL);
      `CHECK(rd, SET_VAL[i])
      `CHECK(lat, 3 + SET_WAITS[i])
    end
    i_cpu_bus_model.access(1'b1, 1'b1, 1'b0, `ADDR_WAIT_CTRL, 8'h24, 3'h0, 0, rd, lat);
    `CHECK(wait_ctl, 8'h11)
    rd8(`ADDR_SYSTEM_STATUS);
    `CHECK(rd, 8'h00)
    rd8(`ADDR_UNLOCK_CMD);
    `CHECK(rd, `UNDEF_READ)
    $display("test wait_setting done");
    for (int i = 0; i < 5; i++) begin
      wr8(PROT_ADDR[i], 8'h5A);
      `CHECK(prot_val[i], 8'h00)
      `CHECK(err, 1'b1)
      wr8(`ADDR_SYSTEM_STATUS, 8'h00);
      `CHECK(err, 1'b0)
    end
    $display("test locked_writes done");
    for (int i = 0; i < 5; i++) begin
      unlock(8'h30 + 8'(i));
      wr8(PROT_ADDR[i], 8'h30 + 8'(i));
      `CHECK(prot_val[i], 8'h30 + 8'(i))
      `CHECK(err, 1'b0)
      wr8(PROT_ADDR[i], 8'hC3);
      `CHECK(prot_val[i], 8'h30 + 8'(i))
      `CHECK(err, 1'b1)
      wr8(`ADDR_SYSTEM_STATUS, 8'h00);
    end
    $display("test unlocked_writes done");
    unlock(8'h66);
    rd8(`ADDR_SYSTEM_STATUS);
    wr8(PROT_ADDR[0], 8'h66);
    `CHECK(prot_val[0], 8'h66)
    `CHECK(err, 1'b0)
    unlock(8'h77);
    rd8(`ADDR_SYSTEM_STATUS);
    wr8(PROT_ADDR[3], 8'h77);
    `CHECK(prot_val[3], 8'h33)
    `CHECK(err, 1'b1)
    wr8(`ADDR_SYSTEM_STATUS, 8'h00);
    $display("test reads_between done");
    unlock(8'h11);
    wr8(`ADDR_WAIT_CTRL, 8'h11);
    `CHECK(err, 1'b1)
    wr8(PROT_ADDR[1], 8'h99);
    `CHECK(prot_val[1], 8'h31)
    wr8(`ADDR_SYSTEM_STATUS, 8'h00);
    unlock(8'h01);
    wbit(`ADDR_WAIT_CTRL, 3'h4, 1'b1);
    `CHECK(err, 1'b1)
    $display("test wrong_target done");
    wr8(`ADDR_SYSTEM_STATUS, 8'h00);
    unlock(8'h00);
    wbit(`ADDR_SYSTEM_STATUS, 3'h3, 1'b1);
    `CHECK(err, 1'b1)
    wr8(`ADDR_SYSTEM_STATUS, 8'h00);
    wr8(`ADDR_SYSTEM_STATUS, 8'h01);
    `CHECK(err, 1'b1)
    rd8(`ADDR_SYSTEM_STATUS);
    `CHECK(rd, 8'h01)
    wbit(`ADDR_SYSTEM_STATUS, 3'h0, 1'b0);
    `CHECK(err, 1'b0)
    wbit(`ADDR_SYSTEM_STATUS, 3'h0, 1'b1);
    `CHECK(err, 1'b1)
    unlock(8'h00);
    wr8(`ADDR_SYSTEM_STATUS, 8'h00);
    `CHECK(err, 1'b0)
    unlock(8'h00);
    unlock(8'h00);
    `CHECK(err, 1'b1)
    wr8(`ADDR_SYSTEM_STATUS, 8'h00);
    `CHECK(err, 1'b0)
    $display("test status_flag done");
    i_cpu_bus_model.access(1'b0, 1'b0, 1'b0, `ADDR_SYSTEM_STATUS, 8'h00, 3'h0, 5, rd, lat);
    // One clash reruns the countdown: base 3, waits 2, rerun of 2 plus the waits
    `CHECK(lat, 3 + 2 + 4)
    `CHECK(rd, 8'h00)
    $display("test clash_retry done");
    wr8(`ADDR_SYSTEM_STATUS, 8'h01);
    do_reset();
    `CHECK(err, 1'b0)
    `CHECK(wait_ctl, 8'h77)
    `CHECK(prot_val[0], 8'h00)
    $display("test mid_reset done");
    end_sim();
  end
endmodule : testbench
